// ### hw/tsoc_regs.svh
/*
  Constants of the transport stream output conditioner: packet layout,
  identifiers, rates and timing counts. Assumes a 100 MHz system clock.
*/
`ifndef TSOC_REGS_SVH
`define TSOC_REGS_SVH

`define TSOC_SYNC_BYTE      8'h47
`define TSOC_NULL_PID       13'h1fff
`define TSOC_ENCAP_PID      13'h1ff6
`define TSOC_OPS_PID        13'h1ffa
`define TSOC_OPTYPE_CTRL    8'h00
`define TSOC_STUFF_BYTE     8'hff
`define TSOC_NULL_FLAGS     8'h10
`define TSOC_PKT_LAST       8'd187
`define TSOC_POS_TEI        8'd1
`define TSOC_POS_PID_LO     8'd2
`define TSOC_POS_OPTYPE     8'd4
`define TSOC_CTRL_FIRST     8'd20
`define TSOC_CTRL_LAST      8'd167
`define TSOC_FIELD_LAST     9'd311
`define TSOC_CLK_HZ         100000000
`define TSOC_OUT_BPS        19392658
`define TSOC_RATE_MOD       (`TSOC_CLK_HZ * 8)
`define TSOC_PRECURSOR_S    1
`define TSOC_PRECURSOR_CYC  (`TSOC_PRECURSOR_S * `TSOC_CLK_HZ)
`define TSOC_NO_INPUT_MS    10
`define TSOC_NO_INPUT_CYC   ((`TSOC_NO_INPUT_MS * `TSOC_CLK_HZ) / 1000)
`define TSOC_TICK_PERIOD_S  1
`define TSOC_TICK_CYC       (`TSOC_TICK_PERIOD_S * `TSOC_CLK_HZ)

`endif

// ### hw/tsoc_pkg.sv
/*
  Types of the transport stream output conditioner.
  Assumes counts of at most 2^28 cycles.
*/
package tsoc_pkg;

  typedef enum logic [1:0] {SRC_IDLE, SRC_IN, SRC_GEN} tsoc_src_t;

  typedef struct packed {
    logic [8:0]  buf0;
    logic [8:0]  buf1;
    logic [1:0]  cnt;
    logic        in_ready;
    logic [29:0] acc;
    logic [7:0]  pos;
    tsoc_src_t   src;
    logic        gen_prec;
    logic [12:0] pid;
    logic        conv;
    logic        encap;
    logic        field_used;
    logic [8:0]  fld;
    logic [27:0] idle;
    logic        no_input;
    logic [27:0] sec;
    logic        prec_due;
    logic [27:0] tcnt;
    logic [7:0]  raw;
    logic [7:0]  out_data;
    logic        out_valid;
    logic        out_sop;
    logic        frsc_take;
    logic        align;
    logic        underrun;
  } tsoc_state_t;

endpackage : tsoc_pkg

// ### hw/tsoc_conditioner.sv
/*
  Output stage of a stream adapter: fixed-rate transport stream framer with
  null-packet handling, control packet conversion, side channel insertion,
  encapsulation packet flagging and advanced tick alignment release.
  Assumes the clock is disciplined to the GPS reference and all inputs are
  synchronous to it.
*/
// Operation
// - Output bytes paced at the fixed rate from the disciplined clock.
// - In mobile mode no null packet is inserted or deleted until input is lost.
// - Input passes unchanged except control and side channel data.
// - In standard mode nulls are inserted when input falls short.
// - With no input, an own packet stream is made at the same rate.
// - Tick alignment released ahead of the tick by maximum delay.
// - Encapsulation packets recognised only by identifier 0x1ff6.
// - Without input: null packets, a precursor packet about once a second.
// - At most one control packet per transmitted data field.
`include "tsoc_regs.svh"

module tsoc_conditioner #(
  parameter int unsigned PRECURSOR_CYC = `TSOC_PRECURSOR_CYC,
  parameter int unsigned NO_INPUT_CYC  = `TSOC_NO_INPUT_CYC,
  parameter int unsigned TICK_CYC      = `TSOC_TICK_CYC
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       mode_mh,
  input  wire logic [7:0] in_data,
  input  wire logic       in_sop,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic       frsc_bit,
  input  wire logic [7:0] ctrl_byte,
  input  wire logic       emission_time_tick,
  input  wire logic [27:0] max_delay_cyc,
  output logic [7:0]      out_data,
  output logic            out_valid,
  output logic            out_sop,
  output logic            mobile_encapsulation_packet,
  output logic            out_ctrl,
  output logic            frsc_take,
  output logic            tick_align,
  output logic            underrun
);
  import tsoc_pkg::*;

  localparam logic [30:0] RATE_STEP = 31'(`TSOC_OUT_BPS);
  localparam logic [30:0] RATE_MOD  = 31'(`TSOC_RATE_MOD);

  tsoc_state_t q;
  tsoc_state_t d;

  // Byte of a locally generated null or precursor packet
  function automatic logic [7:0] gen_byte(input logic [7:0] pos,
                                          input logic       prec);
    logic [12:0] pid;
    pid = prec ? `TSOC_OPS_PID : `TSOC_NULL_PID;
    unique case (pos)
      8'h00:   gen_byte = `TSOC_SYNC_BYTE;
      8'h01:   gen_byte = {3'h0, pid[12:8]};
      8'h02:   gen_byte = pid[7:0];
      8'h03:   gen_byte = `TSOC_NULL_FLAGS;
      8'h04:   gen_byte = prec ? `TSOC_OPTYPE_CTRL : `TSOC_STUFF_BYTE;
      default: gen_byte = `TSOC_STUFF_BYTE;
    endcase
  endfunction : gen_byte

  logic [30:0] acc_sum;
  logic        rate_en;
  logic        pop;
  logic [1:0]  cnt_pop;
  tsoc_src_t   src;
  logic [7:0]  raw;
  logic [7:0]  byte_v;
  logic [27:0] adv;

  always_comb
  begin
    d        = q;
    pop      = 1'b0;
    src      = q.src;
    raw      = 8'h00;
    byte_v   = 8'h00;
    cnt_pop  = q.cnt;
    d.out_valid = 1'b0;
    d.out_sop   = 1'b0;
    d.frsc_take = 1'b0;
    d.align     = 1'b0;
    d.underrun  = 1'b0;
    // Fractional pacing of the byte slots
    acc_sum = {1'b0, q.acc} + RATE_STEP;
    rate_en = acc_sum >= RATE_MOD;
    d.acc   = rate_en ? 30'(acc_sum - RATE_MOD) : acc_sum[29:0];
    // Loss of upstream input
    if (in_valid)
    begin
      d.idle     = 28'h0;
      d.no_input = 1'b0;
    end
    else if (q.idle == 28'(NO_INPUT_CYC - 1))
      d.no_input = 1'b1;
    else
      d.idle = q.idle + 28'h1;
    // Precursor cadence
    if (q.sec == 28'(PRECURSOR_CYC - 1))
    begin
      d.sec      = 28'h0;
      d.prec_due = 1'b1;
    end
    else
      d.sec = q.sec + 28'h1;
    // Tick alignment advanced by the maximum delay
    adv = 28'(TICK_CYC) - max_delay_cyc;
    if (emission_time_tick)
      d.tcnt = 28'h0;
    else if (q.tcnt != 28'hfffffff)
      d.tcnt = q.tcnt + 28'h1;
    d.align = !emission_time_tick && (q.tcnt + 28'h1 == adv);
    // Byte slot
    if (rate_en)
    begin
      if (q.pos == 8'h00)
      begin
        d.src = SRC_IDLE;
        if (q.cnt != 2'd0 && q.buf0[8])
          d.src = SRC_IN;
        else
        begin
          pop = q.cnt != 2'd0;
          if (q.no_input || !mode_mh)
            d.src = SRC_GEN;
        end
        d.gen_prec = d.src == SRC_GEN && q.no_input && q.prec_due;
        if (d.gen_prec && q.sec != 28'(PRECURSOR_CYC - 1))
          d.prec_due = 1'b0;
        src = d.src;
      end
      if (src == SRC_IN && q.cnt == 2'd0)
        d.underrun = 1'b1;
      else if (src != SRC_IDLE)
      begin
        raw    = (src == SRC_IN) ? q.buf0[7:0] : gen_byte(q.pos, d.gen_prec);
        pop    = src == SRC_IN;
        byte_v = raw;
        if (q.pos == 8'h00)
        begin
          d.conv = 1'b0;
          d.encap = 1'b0;
          d.fld  = (q.fld == `TSOC_FIELD_LAST) ? 9'h0 : q.fld + 9'h1;
          if (q.fld == `TSOC_FIELD_LAST)
            d.field_used = 1'b0;
        end
        if (q.pos == `TSOC_POS_TEI)
        begin
          d.pid[12:8] = raw[4:0];
          byte_v[7]   = frsc_bit;
          d.frsc_take = 1'b1;
        end
        if (q.pos == `TSOC_POS_PID_LO)
        begin
          d.pid[7:0] = raw;
          d.encap = {q.pid[12:8], raw} == `TSOC_ENCAP_PID;
        end
        if (q.pos == `TSOC_POS_OPTYPE && q.pid == `TSOC_OPS_PID &&
            raw == `TSOC_OPTYPE_CTRL && !d.field_used)
        begin
          d.conv       = 1'b1;
          d.field_used = 1'b1;
        end
        if (q.conv && q.pos >= `TSOC_CTRL_FIRST && q.pos <= `TSOC_CTRL_LAST)
          byte_v = ctrl_byte;
        d.pos = (q.pos == `TSOC_PKT_LAST) ? 8'h00 : q.pos + 8'h01;
        d.raw       = raw;
        d.out_data  = byte_v;
        d.out_valid = 1'b1;
        d.out_sop   = q.pos == 8'h00;
      end
    end
    // Two-entry buffer in the input path
    if (pop)
    begin
      d.buf0  = q.buf1;
      cnt_pop = q.cnt - 2'd1;
    end
    d.cnt = cnt_pop;
    if (in_valid && q.in_ready)
    begin
      if (cnt_pop == 2'd0)
        d.buf0 = {in_sop, in_data};
      else
        d.buf1 = {in_sop, in_data};
      d.cnt = cnt_pop + 2'd1;
    end
    d.in_ready = d.cnt != 2'd2;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      q          <= '0;
      q.src      <= SRC_IDLE;
      q.tcnt     <= 28'hfffffff;
      q.in_ready <= 1'b1;
    end
    else
      q <= d;
  end

  assign in_ready   = q.in_ready;
  assign out_data   = q.out_data;
  assign out_valid  = q.out_valid;
  assign out_sop    = q.out_sop;
  assign mobile_encapsulation_packet = q.encap;
  assign out_ctrl   = q.conv;
  assign frsc_take  = q.frsc_take;
  assign tick_align = q.align;
  assign underrun   = q.underrun;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  rate_paced_a: assert property (q.out_valid |-> $past(rate_en))
    else $error("Output byte outside a paced slot");
  mh_no_null_a: assert property (
      rate_en && q.pos == 8'h00 && mode_mh && !q.no_input &&
      d.src != SRC_IN |=> !q.out_valid)
    else $error("Null packet made in mobile mode");
  pass_through_a: assert property (
      q.out_valid && q.src == SRC_IN && !q.conv && !q.out_sop &&
      !q.frsc_take |-> q.out_data == q.raw)
    else $error("Input byte altered");
  std_null_a: assert property (
      rate_en && q.pos == 8'h00 && !mode_mh
      |=> q.out_valid && q.out_sop && q.out_data == `TSOC_SYNC_BYTE)
    else $error("Standard mode slot left empty");
  gen_stream_a: assert property (
      rate_en && q.pos == 8'h00 && q.no_input
      |=> q.out_valid ##0 q.out_sop)
    else $error("No own stream without input");
  align_adv_a: assert property (
      q.align |-> !$past(emission_time_tick) &&
      q.tcnt == 28'(TICK_CYC) - max_delay_cyc)
    else $error("Alignment released at wrong advance");
  encap_pid_a: assert property (
      q.out_valid && q.pos > `TSOC_POS_PID_LO
      |-> q.encap == (q.pid == `TSOC_ENCAP_PID))
    else $error("Encapsulation flag wrong");
  prec_rate_a: assert property (
      $rose(q.gen_prec) |-> $past(q.prec_due) && q.sec < 28'(PRECURSOR_CYC))
    else $error("Precursor made without being due");
  one_ctrl_a: assert property (
      $rose(q.conv) |-> !$past(q.field_used))
    else $error("Second control packet in a field");
  whole_pkt_a: assert property (
      q.out_valid && q.out_sop
      |-> q.out_data == `TSOC_SYNC_BYTE && q.pos == 8'h01)
    else $error("Packet split at boundary");

  ctrl_seen_c:  cover property ($rose(q.conv));
  null_ins_c:   cover property (q.out_sop && q.src == SRC_GEN && !mode_mh);
  prec_seen_c:  cover property ($rose(q.gen_prec));
  align_seen_c: cover property (q.align);

endmodule : tsoc_conditioner

// ### testbench/tsoc_mux_model.sv
/*
  Upstream multiplexer model: whole 188-byte packets of one identifier.
  Assumes a registered ready from the conditioner and a 100 MHz clock.
*/
module tsoc_mux_model (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        en,
  input  wire logic [12:0] pid,
  input  wire logic        in_ready,
  output logic [7:0]       in_data,
  output logic             in_sop,
  output logic             in_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  int          idx;
  logic        hs;
  logic [12:0] p;

  function automatic logic [7:0] pkt_byte(int i, logic [12:0] q);
    if (i == 0) return 8'h47;
    if (i == 1) return {3'h0, q[12:8]};
    if (i == 2) return q[7:0];
    if (i == 3) return 8'h10;
    return 8'(i) ^ q[7:0];
  endfunction : pkt_byte

  always @(posedge clock) hs <= in_valid && in_ready;

  // Offer held until taken; an idle line inverts its data on every cycle
  always @(negedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      idx = 0;
      in_valid = 0;
      in_sop = 0;
      in_data = 8'h00;
      p = 13'h0000;
    end
    else
    begin
      if (hs) idx = (idx == 187) ? 0 : idx + 1;
      if (idx == 0 && !en)
      begin
        in_valid = 0;
        in_sop = 0;
        in_data = ~in_data;
      end
      else
      begin
        if (idx == 0) p = pid;
        in_valid = 1;
        in_sop = (idx == 0);
        in_data = pkt_byte(idx, p);
      end
    end
  end
endmodule : tsoc_mux_model

// ### testbench/ts_output_stream_conditioner_test.sv
/*
  Self-checking bench of the output conditioner with an upstream model.
  Assumes the shortened counts set on the instance below.
*/
`define CHK(a, b) \
  begin cmp_count++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t: value mismatch", $time); end end

module ts_output_stream_conditioner_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic mode; logic [12:0] pid; logic encap;} tsoc_row_t;
  tsoc_row_t rows [3] = '{'{1'b1, 13'h1ff6, 1'b1},
    '{1'b0, 13'h0100, 1'b0}, '{1'b0, 13'h1ff7, 1'b0}};
  logic        clock, nrst, mode_mh, frsc_bit, tick, en, encap_seen;
  logic        in_ready, in_sop, in_valid, out_valid, out_sop;
  logic        mobile_encapsulation_packet;
  logic        out_ctrl, frsc_take, tick_align, underrun;
  logic [7:0]  in_data, ctrl_byte, out_data;
  logic [7:0]  pkt [188];
  logic [12:0] pid;
  logic [27:0] max_delay;
  int          fails, cmp_count, cyc, last, idx, nulls, prec, ctrls, und;
  int          data_pkts, n, k, t;

  tsoc_conditioner #(.PRECURSOR_CYC(5000), .NO_INPUT_CYC(3000),
    .TICK_CYC(4000)) dut (.clock(clock), .nrst(nrst), .mode_mh(mode_mh),
    .in_data(in_data), .in_sop(in_sop), .in_valid(in_valid),
    .in_ready(in_ready), .frsc_bit(frsc_bit), .ctrl_byte(ctrl_byte),
    .emission_time_tick(tick), .max_delay_cyc(max_delay),
    .out_data(out_data), .out_valid(out_valid), .out_sop(out_sop),
    .mobile_encapsulation_packet(mobile_encapsulation_packet),
    .out_ctrl(out_ctrl), .frsc_take(frsc_take),
    .tick_align(tick_align), .underrun(underrun));

  tsoc_mux_model mux (.clock(clock), .nrst(nrst), .en(en), .pid(pid),
    .in_ready(in_ready), .in_data(in_data), .in_sop(in_sop),
    .in_valid(in_valid));

  task automatic done_pkt;
    logic [12:0] p;
    p = {pkt[1][4:0], pkt[2]};
    if (p == 13'h1fff)
    begin
      nulls++;
      `CHK({pkt[1], pkt[3], pkt[4]}, 24'h9f10ff)
    end
    else if (p == 13'h1ffa)
    begin
      prec++;
      if (out_ctrl) ctrls++;
      `CHK(out_ctrl, prec == 1)
      `CHK(pkt[20], out_ctrl ? ctrl_byte : 8'hff)
    end
    else
    begin
      if (p == pid) data_pkts++;
      encap_seen = mobile_encapsulation_packet;
      for (int i = 0; i < 188; i++)
        `CHK(pkt[i], mux.pkt_byte(i, p) | (i == 1 ? 8'h80 : 8'h00))
    end
  endtask : done_pkt

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end

  // Output monitor: packet framing, pacing and side channel slot
  always @(negedge clock)
  begin
    cyc++;
    if (underrun) und++;
    if (out_valid)
    begin
      if (out_sop)
      begin
        if (idx > 0) `CHK(idx, 188)
        if (!mode_mh && last > 0)
          `CHK((cyc - last) inside {7755, 7756}, 1'b1)
        last = cyc;
        idx = 0;
      end
      `CHK(frsc_take, idx == 1)
      pkt[idx] = out_data;
      if (idx == 187) done_pkt();
      idx++;
    end
  end

  initial
  begin
    @(posedge nrst);
    repeat (10) @(negedge clock);
    tick = 1;
    @(negedge clock);
    tick = 0;
    for (t = 1; t < 3100 && !tick_align; t++) @(negedge clock);
    `CHK(t inside {[2999:3001]}, 1'b1)
  end

  initial
  begin
    #900000;
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    results();
  end

  initial
  begin
    {nrst, en, tick} = 3'b000;
    mode_mh = 1;
    frsc_bit = 1;
    ctrl_byte = 8'h5a;
    max_delay = 28'd1000;
    pid = 13'h0000;
    repeat (4) @(negedge clock);
    `CHK({in_ready, out_valid}, 2'b10)
    nrst = 1;
    for (int r = 0; r < 3; r++)
    begin
      mode_mh = rows[r].mode;
      pid = rows[r].pid;
      en = 1;
      n = data_pkts + 1;
      for (k = 0; k < 20000 && data_pkts < n; k++) @(negedge clock);
      `CHK(data_pkts >= n, 1'b1)
      `CHK(encap_seen, rows[r].encap)
      if (r == 0) `CHK(nulls, 0)
    end
    en = 0;
    n = nulls;
    for (k = 0; k < 20000 && nulls == n; k++) @(negedge clock);
    `CHK(nulls > n, 1'b1)
    for (k = 0; k < 25000 && prec < 2; k++) @(negedge clock);
    `CHK(prec >= 2, 1'b1)
    `CHK(ctrls, 1)
    `CHK(und, 0)
    results();
  end
endmodule : ts_output_stream_conditioner_test
